// >>> hw/utx_consts.svh
// Offsets, field positions and reset values of the transceiver block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef UTX_CONSTS_SVH
`define UTX_CONSTS_SVH

`define UTX_HALF_W 9
`define UTX_BUS_W 18
`define UTX_ADDR_W 5

`define UTX_OFS_CTRL 5'h00
`define UTX_OFS_BND_B 5'h04
`define UTX_OFS_BND_A 5'h08
`define UTX_OFS_BND_OE 5'h0c
`define UTX_OFS_SNAP_A 5'h10
`define UTX_OFS_SNAP_B 5'h14
`define UTX_OFS_SNAP_CTL 5'h18

`define UTX_CTRL_TEST_BIT 0
`define UTX_CTRL_GANG_BIT 1
`define UTX_BND_OE_B_BIT 0
`define UTX_BND_OE_A_BIT 1

`define UTX_CTRL_RST 2'h0
`define UTX_BND_RST 18'h00000
`define UTX_BND_OE_RST 2'h0

`endif

// >>> hw/utx_path.sv
// One 9-bit half of one direction: latch/flip-flop store and output stage.
// Assumes all inputs are already synchronised to ref_clk.
`timescale 1ns/10ps
`default_nettype none

module utx_path
  import utx_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Normal controls
  input wire logic latch_enable,
  input wire logic data_clock,
  input wire logic output_enable_n,
  input wire utx_half_t din,
  // Test boundary
  input wire logic test_mode,
  input wire utx_half_t bnd_data,
  input wire logic bnd_drive,
  // Pin side
  output utx_half_t dout_q,
  output utx_half_t oe_n_q
);

  utx_half_t store_q;
  utx_half_t store_d;
  logic clk_prev_q;
  logic clk_prev_d;
  utx_half_t dout_d;
  utx_half_t oe_n_d;

  always_comb begin
    clk_prev_d = data_clock;
    store_d = store_q;
    if (latch_enable) begin
      store_d = din;
    end else if (data_clock && !clk_prev_q) begin
      store_d = din;
    end
    if (test_mode) begin
      dout_d = bnd_data;
      oe_n_d = {`UTX_HALF_W{!bnd_drive}};
    end else begin
      dout_d = store_d;
      oe_n_d = {`UTX_HALF_W{output_enable_n}};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      store_q <= '0;
      clk_prev_q <= 1'b0;
      dout_q <= '0;
      oe_n_q <= '1;
    end else begin
      store_q <= store_d;
      clk_prev_q <= clk_prev_d;
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
    end
  end

endmodule

`default_nettype wire

// >>> hw/utx_pkg.sv
// Types shared by the transceiver block.
// Assumes the constants header is included where widths are needed.
`include "utx_consts.svh"

package utx_pkg;
  typedef logic [`UTX_HALF_W-1:0] utx_half_t;
  typedef logic [`UTX_BUS_W-1:0] utx_bus_t;
  typedef logic [`UTX_ADDR_W-1:0] utx_addr_t;
endpackage

// >>> hw/utx_regs.sv
// Avalon-MM register file: control, boundary values and pin snapshots.
// Assumes a master that holds its request until waitrequest is low.
`timescale 1ns/10ps
`default_nettype none

module utx_regs
  import utx_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire utx_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Block state
  input wire utx_bus_t snap_a,
  input wire utx_bus_t snap_b,
  input wire logic [11:0] snap_ctl,
  // Control out
  output logic [1:0] ctrl_q,
  output utx_bus_t bnd_b_q,
  output utx_bus_t bnd_a_q,
  output logic [1:0] bnd_oe_q
);

  logic [1:0] ctrl_d;
  utx_bus_t bnd_b_d;
  utx_bus_t bnd_a_d;
  logic [1:0] bnd_oe_d;
  logic [31:0] rdata_d;
  logic wait_d;
  logic take;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    logic [31:0] m;
    m = '0;
    take = avs_write && !avs_waitrequest;
    ctrl_d = ctrl_q;
    bnd_b_d = bnd_b_q;
    bnd_a_d = bnd_a_q;
    bnd_oe_d = bnd_oe_q;
    wait_d = !((avs_read || avs_write) && avs_waitrequest);
    rdata_d = '0;
    case (avs_address)
      `UTX_OFS_CTRL: begin
        rdata_d = {30'h0, ctrl_q};
        m = merge({30'h0, ctrl_q}, avs_writedata, avs_byteenable);
        if (take) begin
          ctrl_d = m[1:0];
        end
      end
      `UTX_OFS_BND_B: begin
        rdata_d = {14'h0, bnd_b_q};
        m = merge({14'h0, bnd_b_q}, avs_writedata, avs_byteenable);
        if (take) begin
          bnd_b_d = m[17:0];
        end
      end
      `UTX_OFS_BND_A: begin
        rdata_d = {14'h0, bnd_a_q};
        m = merge({14'h0, bnd_a_q}, avs_writedata, avs_byteenable);
        if (take) begin
          bnd_a_d = m[17:0];
        end
      end
      `UTX_OFS_BND_OE: begin
        rdata_d = {30'h0, bnd_oe_q};
        m = merge({30'h0, bnd_oe_q}, avs_writedata, avs_byteenable);
        if (take) begin
          bnd_oe_d = m[1:0];
        end
      end
      `UTX_OFS_SNAP_A: rdata_d = {14'h0, snap_a};
      `UTX_OFS_SNAP_B: rdata_d = {14'h0, snap_b};
      `UTX_OFS_SNAP_CTL: rdata_d = {20'h0, snap_ctl};
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q <= `UTX_CTRL_RST;
      bnd_b_q <= `UTX_BND_RST;
      bnd_a_q <= `UTX_BND_RST;
      bnd_oe_q <= `UTX_BND_OE_RST;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      bnd_b_q <= bnd_b_d;
      bnd_a_q <= bnd_a_d;
      bnd_oe_q <= bnd_oe_d;
      avs_readdata <= rdata_d;
      avs_waitrequest <= wait_d;
    end
  end

endmodule

`default_nettype wire

// >>> hw/utx_top.sv
// Top of the 18-bit two-way bus transceiver with latch and clocked modes.
// Assumes pins arrive asynchronously and are resynchronised to ref_clk.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Latch enable high: B outputs follow A inputs transparently.
// - Latch enable low, clock steady: B holds the stored A value.
// - Latch enable low: A captured on each rising A-to-B clock edge.
// - A-to-B output enable low: B outputs actively driven outside test mode.
// - A-to-B output enable high: B outputs high impedance outside test mode.
// - B-to-A path behaves the same with its own enable, latch, clock.
// - Eighteen bits per direction, two 9-bit halves or one 18-bit unit.
// - Test mode inhibits normal flow; test logic owns the boundary.
// - Sampling pins in normal mode leaves the data flow untouched.
module utx_top
  import utx_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire utx_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Per-half controls, index 0 and 1
  input wire logic [1:0] a_to_b_output_enable_n,
  input wire logic [1:0] b_to_a_output_enable_n,
  input wire logic [1:0] a_to_b_latch_enable,
  input wire logic [1:0] b_to_a_latch_enable,
  input wire logic [1:0] a_to_b_clock,
  input wire logic [1:0] b_to_a_clock,
  // A bus
  input wire utx_bus_t a_bus_in,
  output utx_bus_t a_bus_out,
  output utx_bus_t a_bus_oe_n,
  // B bus
  input wire utx_bus_t b_bus_in,
  output utx_bus_t b_bus_out,
  output utx_bus_t b_bus_oe_n
);

  localparam int PIN_W = 2 * `UTX_BUS_W + 12;
  // Output enables idle high: no drive right after reset
  localparam logic [PIN_W-1:0] SYNC_RST =
    {8'h00, 4'hf, {2*`UTX_BUS_W{1'b0}}};

  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] sync_1_q;
  logic [PIN_W-1:0] sync_2_q;
  logic [PIN_W-1:0] sync_1_d;
  logic [PIN_W-1:0] sync_2_d;
  utx_bus_t a_sync;
  utx_bus_t b_sync;
  logic [11:0] ctl_sync;
  logic [1:0] ab_oe_n;
  logic [1:0] ba_oe_n;
  logic [1:0] ab_le;
  logic [1:0] ba_le;
  logic [1:0] ab_clk;
  logic [1:0] ba_clk;
  logic [1:0] ctrl_q;
  utx_bus_t bnd_b_q;
  utx_bus_t bnd_a_q;
  logic [1:0] bnd_oe_q;
  logic test_mode;
  logic gang;

  assign pins = {b_to_a_clock, a_to_b_clock, b_to_a_latch_enable,
                 a_to_b_latch_enable, b_to_a_output_enable_n,
                 a_to_b_output_enable_n, b_bus_in, a_bus_in};

  // Two-stage synchroniser for every pin input
  always_comb begin
    sync_1_d = pins;
    sync_2_d = sync_1_q;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_1_q <= SYNC_RST;
      sync_2_q <= SYNC_RST;
    end else begin
      sync_1_q <= sync_1_d;
      sync_2_q <= sync_2_d;
    end
  end

  assign a_sync = sync_2_q[`UTX_BUS_W-1:0];
  assign b_sync = sync_2_q[2*`UTX_BUS_W-1:`UTX_BUS_W];
  assign ctl_sync = sync_2_q[PIN_W-1:2*`UTX_BUS_W];
  assign test_mode = ctrl_q[`UTX_CTRL_TEST_BIT];
  assign gang = ctrl_q[`UTX_CTRL_GANG_BIT];

  // Ganged mode: half 1 takes half 0 controls
  always_comb begin
    ab_oe_n = ctl_sync[1:0];
    ba_oe_n = ctl_sync[3:2];
    ab_le = ctl_sync[5:4];
    ba_le = ctl_sync[7:6];
    ab_clk = ctl_sync[9:8];
    ba_clk = ctl_sync[11:10];
    if (gang) begin
      ab_oe_n[1] = ab_oe_n[0];
      ba_oe_n[1] = ba_oe_n[0];
      ab_le[1] = ab_le[0];
      ba_le[1] = ba_le[0];
      ab_clk[1] = ab_clk[0];
      ba_clk[1] = ba_clk[0];
    end
  end

  utx_regs u_regs (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .snap_a(a_sync),
    .snap_b(b_sync),
    .snap_ctl(ctl_sync),
    .ctrl_q(ctrl_q),
    .bnd_b_q(bnd_b_q),
    .bnd_a_q(bnd_a_q),
    .bnd_oe_q(bnd_oe_q)
  );

  for (genvar h = 0; h < 2; h++) begin : g_half
    // A to B store per 9-bit half
    utx_path u_ab (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .latch_enable(ab_le[h]),
      .data_clock(ab_clk[h]),
      .output_enable_n(ab_oe_n[h]),
      .din(a_sync[h*`UTX_HALF_W +: `UTX_HALF_W]),
      .test_mode(test_mode),
      .bnd_data(bnd_b_q[h*`UTX_HALF_W +: `UTX_HALF_W]),
      .bnd_drive(bnd_oe_q[`UTX_BND_OE_B_BIT]),
      .dout_q(b_bus_out[h*`UTX_HALF_W +: `UTX_HALF_W]),
      .oe_n_q(b_bus_oe_n[h*`UTX_HALF_W +: `UTX_HALF_W])
    );
    utx_path u_ba (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .latch_enable(ba_le[h]),
      .data_clock(ba_clk[h]),
      .output_enable_n(ba_oe_n[h]),
      .din(b_sync[h*`UTX_HALF_W +: `UTX_HALF_W]),
      .test_mode(test_mode),
      .bnd_data(bnd_a_q[h*`UTX_HALF_W +: `UTX_HALF_W]),
      .bnd_drive(bnd_oe_q[`UTX_BND_OE_A_BIT]),
      .dout_q(a_bus_out[h*`UTX_HALF_W +: `UTX_HALF_W]),
      .oe_n_q(a_bus_oe_n[h*`UTX_HALF_W +: `UTX_HALF_W])
    );
  end

endmodule

`default_nettype wire

// >>> verif/tb_top.sv
// Bench for the transceiver top: table of path cases, then bus cases.
// Assumes the far-side model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`include "utx_consts.svh"
module tb_top import utx_pkg::*;;
  typedef struct packed {
    logic [1:0] le;
    logic [1:0] oe;
    logic p;
    utx_bus_t v;
    utx_bus_t e;
    utx_bus_t eo;
  } utx_row_s;
  localparam utx_row_s ROWS [7] = '{
    '{2'h3, 2'h0, 1'h0, 18'h2a5c3, 18'h2a5c3, 18'h0},
    '{2'h0, 2'h0, 1'h0, 18'h15a3c, 18'h2a5c3, 18'h0},
    '{2'h0, 2'h0, 1'h1, 18'h15a3c, 18'h15a3c, 18'h0},
    '{2'h1, 2'h0, 1'h0, 18'h3ffff, 18'h15bff, 18'h0},
    '{2'h3, 2'h2, 1'h0, 18'h0, 18'h0, 18'h3fe00},
    '{2'h0, 2'h3, 1'h1, 18'h2a5c3, 18'h0, 18'h3ffff},
    '{2'h0, 2'h0, 1'h0, 18'h0, 18'h2a5c3, 18'h0}};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  utx_addr_t adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wreq;
  logic [1:0] oab = 2'h3;
  logic [1:0] oba = 2'h3;
  logic [1:0] lab = 2'h0;
  logic [1:0] lba = 2'h0;
  logic [1:0] cab = 2'h0;
  logic [1:0] cba = 2'h0;
  utx_bus_t av = '0;
  utx_bus_t bv = '0;
  utx_bus_t ao, aoe, bo, boe, ai, bi;
  int num_errors = 0;
  int tests_run = 0;
  always #2 ref_clk = ~ref_clk;
  utx_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .a_to_b_output_enable_n(oab), .b_to_a_output_enable_n(oba),
    .a_to_b_latch_enable(lab), .b_to_a_latch_enable(lba),
    .a_to_b_clock(cab), .b_to_a_clock(cba), .a_bus_in(ai),
    .a_bus_out(ao), .a_bus_oe_n(aoe), .b_bus_in(bi), .b_bus_out(bo),
    .b_bus_oe_n(boe));
  utx_far far (.a_val(av), .b_val(bv), .a_out(ao), .a_oe_n(aoe),
    .b_out(bo), .b_oe_n(boe), .a_wire(ai), .b_wire(bi));
  task conclude;
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task chk_bus(input utx_bus_t g, input utx_bus_t e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %0t bus %h not %h", $time, g, e);
    end
  endtask
  task chk_word(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %0t word %h not %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input utx_addr_t a, input logic [31:0] d);
    @(posedge ref_clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk);
    end while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task run_row(input logic d, input utx_row_s r);
    @(posedge ref_clk);
    oab <= d ? 2'h3 : r.oe;
    lab <= d ? 2'h0 : r.le;
    oba <= d ? r.oe : 2'h3;
    lba <= d ? r.le : 2'h0;
    if (d) bv <= r.v;
    else av <= r.v;
    step(4);
    cab <= d ? 2'h0 : {2{r.p}};
    cba <= d ? {2{r.p}} : 2'h0;
    step(3);
    cab <= 2'h0;
    cba <= 2'h0;
    step(6);
    chk_bus((d ? ao : bo) & ~r.eo, r.e & ~r.eo);
    chk_bus(d ? aoe : boe, r.eo);
  endtask
  initial begin
    #80000;
    num_errors++;
    conclude;
  end
  initial begin
    step(10);
    sys_rst <= 1'b0;
    step(2);
    chk_bus(boe, '1);
    chk_bus(aoe, '1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, utx_addr_t'(i * 4), 32'h0);
      chk_word(q, 32'h0);
    end
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 7; i++) run_row(d[0], ROWS[i]);
    end
    lab <= 2'h3;
    oab <= 2'h0;
    oba <= 2'h3;
    av <= 18'h1b2e4;
    bus(1'b0, `UTX_OFS_SNAP_A, 32'h0);
    step(4);
    bus(1'b0, `UTX_OFS_SNAP_A, 32'h0);
    chk_word(q, 32'h1b2e4);
    chk_bus(bo, 18'h1b2e4);
    bus(1'b1, `UTX_OFS_BND_B, 32'h2b3c1);
    bus(1'b1, `UTX_OFS_BND_OE, 32'h1);
    bus(1'b1, `UTX_OFS_CTRL, 32'h1);
    av <= 18'h0;
    step(6);
    chk_bus(bo, 18'h2b3c1);
    chk_bus(boe, 18'h0);
    bus(1'b1, `UTX_OFS_CTRL, 32'h0);
    step(6);
    chk_bus(bo, 18'h0);
    bus(1'b1, 5'h1c, 32'hffffffff);
    bus(1'b0, 5'h1c, 32'h0);
    chk_word(q, 32'h0);
    bus(1'b1, `UTX_OFS_CTRL, 32'h2);
    bus(1'b0, `UTX_OFS_CTRL, 32'h0);
    chk_word(q, 32'h2);
    lab <= 2'h1;
    av <= 18'h3c0f5;
    step(6);
    chk_bus(bo, 18'h3c0f5);
    bus(1'b0, `UTX_OFS_SNAP_B, 32'h0);
    chk_word(q, 32'h3c0f5);
    bus(1'b0, `UTX_OFS_SNAP_CTL, 32'h0);
    chk_word(q, 32'h1c);
    conclude;
  end
endmodule
`default_nettype wire

// >>> verif/utx_chk_properties.sv
// Checker on the transceiver top: bus handshake, half 0 data paths.
// Assumes a bind to utx_top; quiet for 4 cycles after reset or test.
`timescale 1ns/10ps
`default_nettype none
`include "utx_consts.svh"
module utx_chk
  import utx_pkg::*;
(
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire utx_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Pins
  input wire logic [1:0] a_to_b_output_enable_n,
  input wire logic [1:0] a_to_b_latch_enable,
  input wire logic [1:0] b_to_a_latch_enable,
  input wire logic [1:0] a_to_b_clock,
  input wire utx_bus_t a_bus_in,
  input wire utx_bus_t b_bus_in,
  input wire utx_bus_t a_bus_out,
  input wire utx_bus_t b_bus_out,
  input wire utx_bus_t b_bus_oe_n
);
  logic tm_q;
  logic tm_d;
  logic ct_w;
  logic [3:0] qh_q;
  // Track the test bit from CTRL writes
  assign ct_w = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_comb begin
    tm_d = tm_q;
    if (ct_w && avs_address == `UTX_OFS_CTRL) begin
      tm_d = avs_writedata[`UTX_CTRL_TEST_BIT];
    end
  end
  always_ff @(posedge ref_clk) begin
    tm_q <= sys_rst ? 1'b0 : tm_d;
    qh_q <= {qh_q[2:0], sys_rst | tm_q};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || qh_q != 4'h0);
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer after request");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer longer than a cycle");
  property p_hiz;
    $past(a_to_b_output_enable_n[0], 3) |-> &b_bus_oe_n[8:0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("B not released");
  property p_drv;
    !$past(a_to_b_output_enable_n[0], 3) |-> b_bus_oe_n[8:0] == 9'h000;
  endproperty
  a_drv: assert property (p_drv) else $error("B not driven");
  property p_flow;
    $past(a_to_b_latch_enable[0], 3)
      |-> b_bus_out[8:0] == $past(a_bus_in[8:0], 3);
  endproperty
  a_flow: assert property (p_flow) else $error("B not following");
  property p_hold;
    !$past(a_to_b_latch_enable[0], 3)
      && !($past(a_to_b_clock[0], 3) && !$past(a_to_b_clock[0], 4))
      |-> $stable(b_bus_out[8:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("B not held");
  property p_cap;
    !$past(a_to_b_latch_enable[0], 3)
      && $past(a_to_b_clock[0], 3) && !$past(a_to_b_clock[0], 4)
      |-> b_bus_out[8:0] == $past(a_bus_in[8:0], 3);
  endproperty
  a_cap: assert property (p_cap) else $error("B not captured");
  property p_back;
    $past(b_to_a_latch_enable[0], 3)
      |-> a_bus_out[8:0] == $past(b_bus_in[8:0], 3);
  endproperty
  a_back: assert property (p_back) else $error("A not following");
endmodule
bind utx_top utx_chk u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest),
  .a_to_b_output_enable_n(a_to_b_output_enable_n),
  .a_to_b_latch_enable(a_to_b_latch_enable),
  .b_to_a_latch_enable(b_to_a_latch_enable),
  .a_to_b_clock(a_to_b_clock), .a_bus_in(a_bus_in), .b_bus_in(b_bus_in),
  .a_bus_out(a_bus_out), .b_bus_out(b_bus_out), .b_bus_oe_n(b_bus_oe_n)
);
`default_nettype wire

// >>> verif/utx_far.sv
// Far-side buses: each bit carries the far value unless the block drives it.
// Assumes per-bit active-low enables from the block.
`timescale 1ns/10ps
`default_nettype none
module utx_far
  import utx_pkg::*;
(
  // Far-side values
  input wire utx_bus_t a_val,
  input wire utx_bus_t b_val,
  // Block side
  input wire utx_bus_t a_out,
  input wire utx_bus_t a_oe_n,
  input wire utx_bus_t b_out,
  input wire utx_bus_t b_oe_n,
  output utx_bus_t a_wire,
  output utx_bus_t b_wire
);
  assign a_wire = (a_oe_n & a_val) | (~a_oe_n & a_out);
  assign b_wire = (b_oe_n & b_val) | (~b_oe_n & b_out);
endmodule
`default_nettype wire
